/* File: logic/i2c_target.sv */
`timescale 1ns/100ps
`default_nettype none
module i2c_target
(
	input  wire logic     link_clk_i,
	input  wire logic     rstn_i,
	input  wire logic     scl_i,
	input  wire logic     sda_i,
	output logic          sda_oe_n_o,
	reg_access_if.target  bus
);
	import sensor_i2c_pkg::*;

	////////////////////////////////////////////////////////////////////
	// pin synchronisers and edge detection
	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic       scl_dly_reg;
	logic       sda_dly_reg;

	always_ff @(posedge link_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			scl_sync_reg <= 2'b11;
			sda_sync_reg <= 2'b11;
			scl_dly_reg  <= 1'b1;
			sda_dly_reg  <= 1'b1;
		end
		else
		begin
			scl_sync_reg <= {scl_sync_reg[0], scl_i};
			sda_sync_reg <= {sda_sync_reg[0], sda_i};
			scl_dly_reg  <= scl_sync_reg[1];
			sda_dly_reg  <= sda_sync_reg[1];
		end
	end

	logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
	assign scl_s     = scl_sync_reg[1];
	assign sda_s     = sda_sync_reg[1];
	assign scl_rise  = scl_s & ~scl_dly_reg;
	assign scl_fall  = ~scl_s & scl_dly_reg;
	assign start_det = scl_s & scl_dly_reg & sda_dly_reg & ~sda_s;
	assign stop_det  = scl_s & scl_dly_reg & ~sda_dly_reg & sda_s;

	////////////////////////////////////////////////////////////////////
	// byte engine
	i2c_state_t state_reg;
	logic [7:0] shift_reg;
	logic [3:0] bit_cnt_reg;
	logic       rw_reg;
	logic       have_ptr_reg;
	logic       host_ack_reg;
	logic       drive_low_reg;
	logic [7:0] ptr_reg;
	logic       wr_stb_reg;
	logic       rd_stb_reg;

	always_ff @(posedge link_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state_reg     <= ST_IDLE;
			shift_reg     <= 8'h00;
			bit_cnt_reg   <= 4'h0;
			rw_reg        <= 1'b0;
			have_ptr_reg  <= 1'b0;
			host_ack_reg  <= 1'b0;
			drive_low_reg <= 1'b0;
			ptr_reg       <= 8'h00;
			wr_stb_reg    <= 1'b0;
			rd_stb_reg    <= 1'b0;
		end
		else
		begin
			wr_stb_reg <= 1'b0;
			rd_stb_reg <= 1'b0;
			if (start_det)
			begin
				// start or repeated start both restart addressing
				state_reg     <= ST_ADDR; // R11
				bit_cnt_reg   <= 4'h0;
				have_ptr_reg  <= 1'b0;
				drive_low_reg <= 1'b0;
			end
			else if (stop_det)
			begin
				state_reg     <= ST_IDLE;
				drive_low_reg <= 1'b0;
			end
			else if (scl_rise)
			begin
				case (state_reg)
					ST_ADDR, ST_WDATA:
					begin
						shift_reg   <= {shift_reg[6:0], sda_s};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
					ST_RDATA:
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					ST_RACK:
						host_ack_reg <= ~sda_s;
					default:
						state_reg <= state_reg;
				endcase
			end
			else if (scl_fall)
			begin
				case (state_reg)
					ST_ADDR:
						if (bit_cnt_reg == 4'h8)
						begin
							if (shift_reg[7:1] == BUS_ADDR)
							begin
								state_reg     <= ST_AACK;
								drive_low_reg <= 1'b1; // R14
								rw_reg        <= shift_reg[0];
							end
							else
								state_reg <= ST_IDLE;
						end
					ST_AACK:
					begin
						bit_cnt_reg <= 4'h0;
						if (rw_reg)
						begin
							state_reg     <= ST_RDATA;
							shift_reg     <= bus.rdata;
							drive_low_reg <= ~bus.rdata[7]; // R14
						end
						else
						begin
							state_reg     <= ST_WDATA;
							drive_low_reg <= 1'b0;
						end
					end
					ST_WDATA:
						if (bit_cnt_reg == 4'h8)
						begin
							state_reg     <= ST_WACK;
							drive_low_reg <= 1'b1; // R14
							if (!have_ptr_reg)
							begin
								ptr_reg      <= shift_reg; // R10
								have_ptr_reg <= 1'b1;
							end
							else
								wr_stb_reg <= 1'b1;
						end
					ST_WACK:
					begin
						state_reg     <= ST_WDATA;
						bit_cnt_reg   <= 4'h0;
						drive_low_reg <= 1'b0;
						if (have_ptr_reg && !wr_stb_reg && bus.wdata == shift_reg)
							ptr_reg <= ptr_reg;
					end
					ST_RDATA:
						if (bit_cnt_reg == 4'h8)
						begin
							state_reg     <= ST_RACK;
							drive_low_reg <= 1'b0;
							ptr_reg       <= ptr_reg + 8'h01; // R12
							rd_stb_reg    <= 1'b1;
						end
						else
						begin
							shift_reg     <= {shift_reg[6:0], 1'b0};
							drive_low_reg <= ~shift_reg[6];
						end
					ST_RACK:
						if (host_ack_reg)
						begin
							state_reg     <= ST_RDATA;
							bit_cnt_reg   <= 4'h0;
							shift_reg     <= bus.rdata; // R12
							drive_low_reg <= ~bus.rdata[7];
						end
						else
							state_reg <= ST_IDLE;
					default:
						drive_low_reg <= 1'b0;
				endcase
			end
		end
	end

	assign sda_oe_n_o = ~drive_low_reg;
	assign bus.ptr    = ptr_reg;
	assign bus.wdata  = shift_reg;
	assign bus.wr_stb = wr_stb_reg;
	assign bus.rd_stb = rd_stb_reg;

	////////////////////////////////////////////////////////////////////
	// checks
	a_addr_ack_drive: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
		(scl_fall && state_reg == ST_ADDR && bit_cnt_reg == 4'h8 && !start_det && !stop_det
		&& shift_reg[7:1] == BUS_ADDR) |=> (state_reg == ST_AACK && !sda_oe_n_o)) // R14
		else $error("address match not acknowledged");
	a_ptr_after_read: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
		rd_stb_reg |-> ptr_reg == $past(ptr_reg) + 8'h01) // R12
		else $error("pointer did not advance after read");
	a_ptr_loaded: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
		($rose(have_ptr_reg) && !start_det) |-> ptr_reg == $past(shift_reg)) // R10
		else $error("pointer not taken from first data byte");
	a_restart_addr: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
		start_det |=> (state_reg == ST_ADDR && bit_cnt_reg == 4'h0 && sda_oe_n_o)) // R11
		else $error("repeated start not accepted");
	c_read_byte: cover property (@(posedge link_clk_i) disable iff (!rstn_i) rd_stb_reg);
	c_repeated_start: cover property (@(posedge link_clk_i) disable iff (!rstn_i)
		start_det && state_reg == ST_WDATA);
endmodule // i2c_target
`default_nettype wire

/* File: logic/reg_access_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface reg_access_if;
	logic       wr_stb;
	logic       rd_stb;
	logic [7:0] ptr;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport target
	(
		output wr_stb,
		output rd_stb,
		output ptr,
		output wdata,
		input  rdata
	);
	modport regs
	(
		input  wr_stb,
		input  rd_stb,
		input  ptr,
		input  wdata,
		output rdata
	);
endinterface
`default_nettype wire

/* File: logic/sensor_i2c_pkg.sv */
`default_nettype none
package sensor_i2c_pkg;

	// register map
	localparam logic [7:0] REG_MOD_TIMING = 8'h8f;
	localparam logic [7:0] REG_AMBIENT_IR = 8'h90;
	localparam logic [7:0] MOD_TIMING_RST = 8'h01;
	localparam logic [7:0] READ_ZERO      = 8'h00;

	// modulator timing field layout
	localparam int DELAY_LSB = 5;
	localparam int FREQ_LSB  = 3;
	localparam int DEAD_LSB  = 0;

	// bus address of the target
	localparam logic [6:0] BUS_ADDR = 7'h13;

	// core clock and modulation half periods in core cycles
	localparam int CORE_CLK_KHZ = 25000;
	localparam logic [5:0] HALF_F0 = 6'(CORE_CLK_KHZ / 781);
	localparam logic [5:0] HALF_F1 = 6'(CORE_CLK_KHZ / 1562);
	localparam logic [5:0] HALF_F2 = 6'(CORE_CLK_KHZ / 3125);
	localparam logic [5:0] HALF_F3 = 6'(CORE_CLK_KHZ / 6250);

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_ADDR   = 3'b001,
		ST_AACK   = 3'b010,
		ST_WDATA  = 3'b011,
		ST_WACK   = 3'b100,
		ST_RDATA  = 3'b101,
		ST_RACK   = 3'b110
	} i2c_state_t;

	function automatic logic [5:0] half_period(input logic [1:0] code);
		case (code)
			2'b00:   half_period = HALF_F0;
			2'b01:   half_period = HALF_F1;
			2'b10:   half_period = HALF_F2;
			default: half_period = HALF_F3;
		endcase
	endfunction

endpackage
`default_nettype wire

/* File: logic/sensor_i2c_top.sv */
// What this block does
// [R1] Read/write delay field shifts IR evaluation after emitter drive; resets to zero.
// [R2] Read/write dead-time field blanks evaluation near signal edges; resets to one.
// [R3] Host uses dead time carefully, since it lowers measured signal level.
// [R4] Host programs modulator timing register to one, equal to its reset value.
// [R5] Recommended settings: delay zero, dead time one, frequency code zero.
// [R6] Host leaves reserved ambient IR level register alone; it reads zero.
// [R7] Without any measurement running the block sits in standby, bus only active.
// [R8] Emitter current sink is off throughout standby.
// [R9] Standby holds whenever no proximity or ambient request is carried out.
// [R10] Write with register address byte only sets the pointer for later reads.
// [R11] Stop between pointer write and read is optional; repeated start works too.
// [R12] Pointer increments after every read byte, reaching the next register.
// [R13] Two-bit frequency code picks 390.625 kHz, 781.25 kHz, 1.5625 or 3.125 MHz.
// [R14] Target acknowledges address and register byte, and drives read data.
`timescale 1ns/100ps
`default_nettype none
module sensor_i2c_top
(
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic link_clk_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe_n_o,
	input  wire logic prox_req_i,
	input  wire logic als_req_i,
	output logic      standby_o,
	output logic      sink_en_o,
	output logic      emitter_drive_o,
	output logic      eval_en_o,
	output logic      eval_phase_o,
	output logic [7:0] mod_timing_o
);
	import sensor_i2c_pkg::*;

	////////////////////////////////////////////////////////////////////
	// link domain: bus target and register store
	reg_access_if bus ();

	i2c_target u_target
	(
		.link_clk_i (link_clk_i),
		.rstn_i     (rstn_i),
		.scl_i      (scl_i),
		.sda_i      (sda_i),
		.sda_oe_n_o (sda_oe_n_o),
		.bus        (bus)
	);

	logic [7:0] mod_link_reg;
	logic       sda_low_reg;

	always_ff @(posedge link_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			mod_link_reg <= MOD_TIMING_RST; // R1 R2 R5
			sda_low_reg  <= 1'b0;
		end
		else if (bus.wr_stb && bus.ptr == REG_MOD_TIMING)
			mod_link_reg <= bus.wdata; // R1 R2 R13
	end

	assign sda_o = sda_low_reg;

	// reserved and unmapped addresses read as zero
	always_comb
	begin
		if (bus.ptr == REG_MOD_TIMING)
			bus.rdata = mod_link_reg; // R14
		else if (bus.ptr == REG_AMBIENT_IR)
			bus.rdata = READ_ZERO; // R6
		else
			bus.rdata = READ_ZERO;
	end

	////////////////////////////////////////////////////////////////////
	// toggle handshake carrying the timing word to the core
	logic [7:0] xfer_data_reg;
	logic       req_tog_reg;
	logic [1:0] ack_sync_reg;
	logic       ack_tog_reg;

	always_ff @(posedge link_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			xfer_data_reg <= MOD_TIMING_RST;
			req_tog_reg   <= 1'b0;
			ack_sync_reg  <= 2'b00;
		end
		else
		begin
			ack_sync_reg <= {ack_sync_reg[0], ack_tog_reg};
			if (req_tog_reg == ack_sync_reg[1] && xfer_data_reg != mod_link_reg)
			begin
				xfer_data_reg <= mod_link_reg;
				req_tog_reg   <= ~req_tog_reg;
			end
		end
	end

	logic [1:0] req_sync_reg;
	logic [7:0] mod_core_reg;

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			req_sync_reg <= 2'b00;
			ack_tog_reg  <= 1'b0;
			mod_core_reg <= MOD_TIMING_RST;
		end
		else
		begin
			req_sync_reg <= {req_sync_reg[0], req_tog_reg};
			if (req_sync_reg[1] != ack_tog_reg)
			begin
				mod_core_reg <= xfer_data_reg;
				ack_tog_reg  <= req_sync_reg[1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// core domain: standby and emitter modulator
	logic [2:0] delay_f, dead_f;
	logic [1:0] freq_f;
	logic [5:0] half_p, period_m1, phase_reg, ph_shift, ph_local;
	logic       busy;

	assign delay_f   = mod_core_reg[DELAY_LSB +: 3];
	assign freq_f    = mod_core_reg[FREQ_LSB +: 2];
	assign dead_f    = mod_core_reg[DEAD_LSB +: 3];
	assign half_p    = half_period(freq_f); // R13
	assign period_m1 = 6'((half_p << 1) - 6'd1);
	assign busy      = prox_req_i | als_req_i;

	// phase seen by the evaluator lags the emitter by the delay
	assign ph_shift = (phase_reg >= {3'b000, delay_f}) ? 6'(phase_reg - {3'b000, delay_f})
		: 6'(phase_reg + period_m1 + 6'd1 - {3'b000, delay_f}); // R1
	assign ph_local = (ph_shift < half_p) ? ph_shift : 6'(ph_shift - half_p);

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			phase_reg <= 6'h00;
		else if (!prox_req_i || phase_reg >= period_m1)
			phase_reg <= 6'h00; // R13
		else
			phase_reg <= phase_reg + 6'h01;
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			standby_o       <= 1'b1;
			sink_en_o       <= 1'b0;
			emitter_drive_o <= 1'b0;
			eval_en_o       <= 1'b0;
			eval_phase_o    <= 1'b0;
			mod_timing_o    <= MOD_TIMING_RST;
		end
		else
		begin
			standby_o       <= ~busy; // R7 R9
			sink_en_o       <= prox_req_i; // R8
			emitter_drive_o <= prox_req_i && (phase_reg < half_p); // R8 R13
			eval_en_o       <= prox_req_i && (ph_local >= {3'b000, dead_f})
				&& ({3'b000, dead_f} < half_p)
				&& (ph_local < 6'(half_p - {3'b000, dead_f})); // R2
			eval_phase_o    <= ph_shift < half_p;
			mod_timing_o    <= mod_core_reg;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	a_standby_idle: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!busy |=> standby_o) // R7
		else $error("not in standby while idle");
	a_standby_busy: assert property (@(posedge clk_i) disable iff (!rstn_i)
		busy |=> !standby_o) // R9
		else $error("standby during a measurement");
	a_sink_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
		standby_o |-> (!sink_en_o && !emitter_drive_o)) // R8
		else $error("emitter sink active in standby");
	a_mod_reset: assert property (@(posedge clk_i)
		!rstn_i |=> (mod_core_reg[DELAY_LSB +: 3] == 3'h0 && mod_core_reg[DEAD_LSB +: 3] == 3'h1
		&& mod_core_reg[FREQ_LSB +: 2] == 2'h0)) // R1 R2 R5
		else $error("timing fields wrong after reset");
	a_square_wave: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(prox_req_i && phase_reg == 6'h00 && $stable(mod_core_reg)) ##1 prox_req_i
		|=> emitter_drive_o) // R13
		else $error("emitter not high at phase start");
	a_dead_blank: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(ph_local < {3'b000, dead_f}) |=> !eval_en_o) // R2
		else $error("evaluation inside dead time");
	c_prox_run: cover property (@(posedge clk_i) disable iff (!rstn_i) prox_req_i ##8 eval_en_o);
	c_timing_update: cover property (@(posedge clk_i) disable iff (!rstn_i) $changed(mod_core_reg));
	c_als_only: cover property (@(posedge clk_i) disable iff (!rstn_i) als_req_i && !prox_req_i);
endmodule // sensor_i2c_top
`default_nettype wire

/* File: sim/i2c_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model
(
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_oe_n_o
);
	localparam int Q = 500;
	localparam int HOLD = 100;

	initial
	begin
		scl_o      = 1'b1;
		sda_oe_n_o = 1'b1;
	end

	////////////////////////////////////////////////////////////////
	// start, also serves as repeated start after scl low
	task automatic start();
		sda_oe_n_o = 1'b1;
		#Q scl_o = 1'b1;
		#Q sda_oe_n_o = 1'b0;
		#Q scl_o = 1'b0;
		#HOLD;
	endtask

	task automatic stop();
		sda_oe_n_o = 1'b0;
		#Q scl_o = 1'b1;
		#Q sda_oe_n_o = 1'b1;
		#Q;
	endtask

	// sda changes only while scl low, with hold after the fall
	task automatic bit_io(input logic b, output logic s);
		sda_oe_n_o = b;
		#Q scl_o = 1'b1;
		#Q s = sda_i;
		scl_o = 1'b0;
		#HOLD;
	endtask

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask

	// last = 1 ends the read with a nack
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(last, s);
	endtask
endmodule // i2c_host_model
`default_nettype wire

/* File: sim/sensor_i2c_read_and_modulator_cfg_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module sensor_i2c_read_and_modulator_cfg_tb;
	import sensor_i2c_pkg::*;

	typedef struct packed {logic [7:0] wdata; logic rs; logic [7:0] exp_rd;} row_t;

	logic       clk_i, rstn_i, link_clk_i, scl_i, sda_w, host_oe_n;
	logic       sda_o, sda_oe_n_o, prox_req_i, als_req_i, standby_o, sink_en_o;
	logic       emitter_drive_o, eval_en_o, eval_phase_o, ack, prev, pe, pp;
	logic [7:0] mod_timing_o, got;
	int         err_total, checks, tg, te, tp;
	row_t       rows [5] = '{'{8'he5, 1'b0, 8'he5}, '{8'h08, 1'b1, 8'h08},
		'{8'h10, 1'b0, 8'h10}, '{8'h18, 1'b1, 8'h18}, '{8'h01, 1'b0, 8'h01}};

	// open drain with pull-up
	assign sda_w = host_oe_n & sda_oe_n_o;

	sensor_i2c_top u_dut
	(
		.clk_i           (clk_i),
		.rstn_i          (rstn_i),
		.link_clk_i      (link_clk_i),
		.scl_i           (scl_i),
		.sda_i           (sda_w),
		.sda_o           (sda_o),
		.sda_oe_n_o      (sda_oe_n_o),
		.prox_req_i      (prox_req_i),
		.als_req_i       (als_req_i),
		.standby_o       (standby_o),
		.sink_en_o       (sink_en_o),
		.emitter_drive_o (emitter_drive_o),
		.eval_en_o       (eval_en_o),
		.eval_phase_o    (eval_phase_o),
		.mod_timing_o    (mod_timing_o)
	);

	i2c_host_model u_host
	(
		.sda_i      (sda_w),
		.scl_o      (scl_i),
		.sda_oe_n_o (host_oe_n)
	);

	////////////////////////////////////////////////////////////////
	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	initial
	begin
		link_clk_i = 1'b0;
		#5;
		forever #24 link_clk_i = ~link_clk_i;
	end

	////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic stop_test();
		if (err_total == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic wb(input logic [7:0] d, input logic exp_ack);
		u_host.wbyte(d, ack);
		check("ack", {7'h00, ack}, {7'h00, exp_ack});
	endtask

	task automatic set_ptr(input logic [7:0] p);
		u_host.start();
		wb({BUS_ADDR, 1'b0}, 1'b1);
		wb(p, 1'b1);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		rstn_i     = 1'b0;
		prox_req_i = 1'b0;
		als_req_i  = 1'b0;
		err_total  = 0;
		checks     = 0;
		tick(2);
		check("mod_timing_rst", mod_timing_o, 8'h01);
		check("standby_rst", {7'h00, standby_o}, 8'h01);
		check("sink_rst", {7'h00, sink_en_o}, 8'h00);
		check("sda_oe_rst", {7'h00, sda_oe_n_o}, 8'h01);
		check("sda_o_rst", {7'h00, sda_o}, 8'h00);
		rstn_i = 1'b1;
		tick(5);
		foreach (rows[i])
		begin
			set_ptr(REG_MOD_TIMING);
			wb(rows[i].wdata, 1'b1);
			u_host.stop();
			tick(10);
			check("mod_timing", mod_timing_o, rows[i].wdata);
			set_ptr(REG_MOD_TIMING);
			if (!rows[i].rs)
				u_host.stop();
			u_host.start();
			wb({BUS_ADDR, 1'b1}, 1'b1);
			u_host.rbyte(1'b0, got);
			check("read", got, rows[i].exp_rd);
			u_host.rbyte(1'b1, got);
			check("read_next", got, 8'h00);
			u_host.stop();
		end
		// foreign address left unanswered
		u_host.start();
		wb(8'h50, 1'b0);
		u_host.stop();
		// write into the reserved place has no effect
		set_ptr(REG_AMBIENT_IR);
		u_host.wbyte(8'h55, ack);
		u_host.stop();
		tick(10);
		check("mod_timing_kept", mod_timing_o, 8'h01);
		set_ptr(REG_AMBIENT_IR);
		u_host.start();
		wb({BUS_ADDR, 1'b1}, 1'b1);
		u_host.rbyte(1'b1, got);
		check("reserved_read", got, 8'h00);
		u_host.stop();
		// proximity request leaves standby and turns the sink on
		tick(1);
		prox_req_i = 1'b1;
		tick(1);
		check("standby_prox", {7'h00, standby_o}, 8'h00);
		check("sink_prox", {7'h00, sink_en_o}, 8'h01);
		tick(8);
		prev = emitter_drive_o;
		pe   = eval_en_o;
		pp   = eval_phase_o;
		tg   = 0;
		te   = 0;
		tp   = 0;
		repeat (128)
		begin
			tick(1);
			if (emitter_drive_o !== prev)
				tg++;
			if (eval_en_o !== pe)
				te++;
			if (eval_phase_o !== pp)
				tp++;
			prev = emitter_drive_o;
			pe   = eval_en_o;
			pp   = eval_phase_o;
		end
		check("emitter_toggles", 8'(tg), 8'h04);
		check("eval_en_toggles", 8'(te), 8'h08);
		check("eval_phase_toggles", 8'(tp), 8'h04);
		prox_req_i = 1'b0;
		als_req_i  = 1'b1;
		tick(1);
		check("standby_als", {7'h00, standby_o}, 8'h00);
		check("sink_als", {7'h00, sink_en_o}, 8'h00);
		als_req_i = 1'b0;
		tick(1);
		check("standby_idle", {7'h00, standby_o}, 8'h01);
		check("sink_idle", {7'h00, sink_en_o}, 8'h00);
		stop_test();
	end

	// hang guard, well beyond the expected run
	initial
	begin
		#2000000;
		err_total++;
		stop_test();
	end
endmodule // sensor_i2c_read_and_modulator_cfg_tb
`default_nettype wire
